// ### rtl/dcm_pkg.sv
// shared constants, mode enumeration and state record of the dual clock mode controller
package dcm_pkg;

    // register byte offsets on the wishbone slave
    localparam logic [3:0] OFS_SYS_ONE    = 4'h0;
    localparam logic [3:0] OFS_SYS_TWO    = 4'h4;
    localparam logic [3:0] OFS_TB_CTRL    = 4'h8;
    localparam logic [3:0] OFS_MODE_STAT  = 4'hc;

    // sys_control_one fields
    localparam int STOP_BIT  = 7;
    localparam int RELM_BIT  = 6;
    localparam int RETM_BIT  = 5;
    // sys_control_two fields
    localparam int FEN_BIT   = 7;
    localparam int SEN_BIT   = 6;
    localparam int CSEL_BIT  = 5;
    localparam int IDLE_BIT  = 4;
    localparam int TGH_BIT   = 2;
    // time_base_control fields
    localparam int TBEN_BIT  = 3;
    // mode status fields
    localparam int ST_FOSC   = 4;
    localparam int ST_SOSC   = 5;
    localparam int ST_IRQ    = 6;

    // reset values of the software visible bytes
    localparam logic [7:0] SYS_ONE_RST = 8'h00;
    localparam logic [7:0] SYS_TWO_RST = 8'h80;
    localparam logic [7:0] TB_CTRL_RST = 8'h00;

    // machine cycle is four periods of the selected oscillator
    localparam logic [1:0] MC_LAST_TICK = 2'h3;
    // slow machine cycle at 32.768 kHz, in microseconds
    localparam int SLOW_MC_US = 122;
    // warm-up length in clk cycles after stop release
    localparam logic [15:0] WARMUP_DEF = 16'h2000;

    typedef enum logic [3:0] {
        single_fast_run,
        dual_fast_run,
        slow_run_fast_on,
        slow_only_run,
        single_idle,
        dual_fast_idle,
        slow_only_idle,
        slow_idle_fast_on,
        fast_base_sleep,
        slow_base_sleep,
        stop_hold,
        stop_warmup
    } dcm_mode_t;

    typedef struct packed {
        dcm_mode_t   mode;
        logic        sel_slow_act;
        logic        clk_sel_req;
        logic        stop;
        logic        relm;
        logic        retm;
        logic        fast_en;
        logic        slow_en;
        logic        idle;
        logic        tg_halt;
        logic        tb_en;
        logic [2:0]  tb_src;
        logic        irq_latch;
        logic        tb_at_entry;
        logic [1:0]  mc_cnt;
        logic        mc_pulse;
        logic        rel_prev;
        logic        tb_prev;
        logic [15:0] warm_cnt;
        logic        ack;
        logic [31:0] dat;
        logic        rst_req;
        logic        resume;
    } dcm_state_t;

    localparam dcm_state_t DCM_RESET_ST = '{mode: single_fast_run, fast_en: 1'b1, default: '0};

endpackage

// ### rtl/dcm_dual_clock_mode_controller.sv
// dual clock operating mode controller with wishbone register access
`timescale 1ns/1ps
`default_nettype none

module dcm_dual_clock_mode_controller #(
    parameter logic [15:0] WARMUP_CYCLES = dcm_pkg::WARMUP_DEF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    // oscillator edge enables and wake sources
    input  wire logic        fast_tick,
    input  wire logic        slow_tick,
    input  wire logic        wake_irq,
    input  wire logic        stop_release_pin,
    input  wire logic [7:0]  tb_sources,
    // cpu interrupt flags
    input  wire logic        interrupt_master_enable,
    input  wire logic        time_base_irq_enable,
    // clock gating and status
    output logic             fast_osc_on,
    output logic             slow_osc_on,
    output logic             slow_pins_dedicated,
    output logic             cpu_clk_en,
    output logic             wdt_clk_en,
    output logic             periph_clk_en,
    output logic             tbt_clk_en,
    output logic             div_low_run,
    output logic             main_clk_slow,
    output logic             machine_cycle,
    output logic             time_base_irq_latch,
    output logic             time_base_irq_take,
    output logic             sys_reset_req,
    output logic             stop_resume
);

    dcm_pkg::dcm_state_t s_r;
    dcm_pkg::dcm_state_t s_nxt;

    logic       tick;
    logic       tb_level;
    logic       tb_fall;
    logic       stop_rel;
    logic       wr_go;
    logic       bad_enables;
    logic [7:0] wr_byte;

    function automatic logic is_run(input dcm_pkg::dcm_mode_t m);
        return (m == dcm_pkg::single_fast_run) || (m == dcm_pkg::dual_fast_run) ||
               (m == dcm_pkg::slow_run_fast_on) || (m == dcm_pkg::slow_only_run);
    endfunction

    function automatic logic divider_stopped(input dcm_pkg::dcm_mode_t m);
        return (m == dcm_pkg::slow_only_run) || (m == dcm_pkg::slow_only_idle) ||
               (m == dcm_pkg::slow_idle_fast_on) || (m == dcm_pkg::slow_base_sleep) ||
               (m == dcm_pkg::stop_hold) || (m == dcm_pkg::stop_warmup);
    endfunction

    function automatic logic is_stopped(input dcm_pkg::dcm_mode_t m);
        return (m == dcm_pkg::stop_hold) || (m == dcm_pkg::stop_warmup);
    endfunction

    assign tick     = s_r.sel_slow_act ? slow_tick : (fast_tick & s_r.fast_en);
    assign tb_level = tb_sources[s_r.tb_src];
    assign tb_fall  = s_r.tb_prev & ~tb_level;
    assign stop_rel = s_r.relm ? stop_release_pin : (stop_release_pin & ~s_r.rel_prev);
    assign wr_go    = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack & wb_sel_i[0];
    assign wr_byte  = wb_dat_i[7:0];
    // clearing the oscillator that drives the system clock is fatal
    assign bad_enables = wr_go && (wb_adr_i == dcm_pkg::OFS_SYS_TWO) &&
        ((!wr_byte[dcm_pkg::FEN_BIT] && !wr_byte[dcm_pkg::SEN_BIT]) ||
         (!wr_byte[dcm_pkg::FEN_BIT] && !s_r.sel_slow_act) ||
         (!wr_byte[dcm_pkg::SEN_BIT] && s_r.sel_slow_act));

    always_comb begin
        s_nxt          = s_r;
        s_nxt.mc_pulse = 1'b0;
        s_nxt.rst_req  = 1'b0;
        s_nxt.resume   = 1'b0;
        s_nxt.rel_prev = stop_release_pin;
        s_nxt.tb_prev  = tb_level;
        s_nxt.ack      = wb_cyc_i & wb_stb_i & ~s_r.ack;

        // machine cycle counter on the selected oscillator
        if (tick && !is_stopped(s_r.mode)) begin
            s_nxt.mc_cnt = s_r.mc_cnt + 2'h1;
            if (s_r.mc_cnt == dcm_pkg::MC_LAST_TICK) begin
                s_nxt.mc_pulse = 1'b1;
                // source changes only between cycles, never mid-pulse
                if (is_run(s_r.mode) && (s_r.clk_sel_req ? s_r.slow_en : s_r.fast_en)) begin
                    s_nxt.sel_slow_act = s_r.clk_sel_req;
                end
            end
        end

        case (s_r.mode)
            dcm_pkg::single_fast_run, dcm_pkg::dual_fast_run: begin
                if (s_r.stop) begin
                    s_nxt.mode = dcm_pkg::stop_hold;
                end else if (s_r.tg_halt) begin
                    s_nxt.mode        = dcm_pkg::fast_base_sleep;
                    s_nxt.tb_at_entry = s_r.tb_en;
                end else if (s_r.idle) begin
                    s_nxt.mode = s_r.slow_en ? dcm_pkg::dual_fast_idle
                                             : dcm_pkg::single_idle;
                end else if (s_r.sel_slow_act) begin
                    s_nxt.mode = dcm_pkg::slow_run_fast_on;
                end else begin
                    s_nxt.mode = s_r.slow_en ? dcm_pkg::dual_fast_run
                                             : dcm_pkg::single_fast_run;
                end
            end
            dcm_pkg::slow_run_fast_on: begin
                if (s_r.stop) begin
                    s_nxt.mode = dcm_pkg::stop_hold;
                end else if (s_r.tg_halt) begin
                    s_nxt.mode        = dcm_pkg::slow_base_sleep;
                    s_nxt.tb_at_entry = s_r.tb_en;
                end else if (s_r.idle) begin
                    // a fast enable cleared by the idle write idles as slow only
                    s_nxt.mode = s_r.fast_en ? dcm_pkg::slow_idle_fast_on
                                             : dcm_pkg::slow_only_idle;
                end else if (!s_r.sel_slow_act) begin
                    s_nxt.mode = dcm_pkg::dual_fast_run;
                end else if (!s_r.fast_en) begin
                    s_nxt.mode = dcm_pkg::slow_only_run;
                end
            end
            dcm_pkg::slow_only_run: begin
                if (s_r.stop) begin
                    s_nxt.mode = dcm_pkg::stop_hold;
                end else if (s_r.tg_halt) begin
                    s_nxt.mode        = dcm_pkg::slow_base_sleep;
                    s_nxt.tb_at_entry = s_r.tb_en;
                end else if (s_r.idle) begin
                    s_nxt.mode = s_r.fast_en ? dcm_pkg::slow_idle_fast_on
                                             : dcm_pkg::slow_only_idle;
                end else if (s_r.fast_en) begin
                    s_nxt.mode = dcm_pkg::slow_run_fast_on;
                end
            end
            dcm_pkg::single_idle, dcm_pkg::dual_fast_idle,
            dcm_pkg::slow_only_idle, dcm_pkg::slow_idle_fast_on: begin
                if (wake_irq) begin
                    s_nxt.idle = 1'b0;
                    case (s_r.mode)
                        dcm_pkg::single_idle:    s_nxt.mode = dcm_pkg::single_fast_run;
                        dcm_pkg::dual_fast_idle: s_nxt.mode = dcm_pkg::dual_fast_run;
                        dcm_pkg::slow_only_idle: s_nxt.mode = dcm_pkg::slow_only_run;
                        default:                 s_nxt.mode = dcm_pkg::slow_run_fast_on;
                    endcase
                end
            end
            dcm_pkg::fast_base_sleep, dcm_pkg::slow_base_sleep: begin
                // leaves on the edge whatever time_base_enable holds
                if (tb_fall) begin
                    s_nxt.tg_halt = 1'b0;
                    if (s_r.tb_at_entry) begin
                        s_nxt.irq_latch = 1'b1;
                    end
                    if (s_r.mode == dcm_pkg::slow_base_sleep) begin
                        s_nxt.mode    = dcm_pkg::slow_only_run;
                        s_nxt.fast_en = 1'b0;
                    end else begin
                        s_nxt.mode = s_r.slow_en ? dcm_pkg::dual_fast_run
                                                 : dcm_pkg::single_fast_run;
                    end
                end
            end
            dcm_pkg::stop_hold: begin
                // other state is held here; bus writes, ack, read data and edge samplers still update
                if (stop_rel) begin
                    s_nxt.mode     = dcm_pkg::stop_warmup;
                    s_nxt.warm_cnt = 16'h0000;
                end
            end
            dcm_pkg::stop_warmup: begin
                s_nxt.warm_cnt = s_r.warm_cnt + 16'h0001;
                if (s_r.warm_cnt == WARMUP_CYCLES - 16'h0001) begin
                    s_nxt.stop   = 1'b0;
                    s_nxt.resume = 1'b1;
                    s_nxt.mc_cnt = 2'h0;
                    if (s_r.retm) begin
                        s_nxt.mode         = dcm_pkg::slow_only_run;
                        s_nxt.fast_en      = 1'b0;
                        s_nxt.sel_slow_act = 1'b1;
                        s_nxt.clk_sel_req  = 1'b1;
                    end else begin
                        s_nxt.mode         = s_r.slow_en ? dcm_pkg::dual_fast_run
                                                         : dcm_pkg::single_fast_run;
                        s_nxt.sel_slow_act = 1'b0;
                        s_nxt.clk_sel_req  = 1'b0;
                    end
                end
            end
            default: s_nxt.mode = dcm_pkg::single_fast_run;
        endcase

        // register writes commit at the edge that sees ack
        if (wr_go) begin
            case (wb_adr_i)
                dcm_pkg::OFS_SYS_ONE: begin
                    s_nxt.stop = wr_byte[dcm_pkg::STOP_BIT];
                    s_nxt.relm = wr_byte[dcm_pkg::RELM_BIT];
                    s_nxt.retm = wr_byte[dcm_pkg::RETM_BIT];
                end
                dcm_pkg::OFS_SYS_TWO: begin
                    s_nxt.fast_en     = wr_byte[dcm_pkg::FEN_BIT];
                    s_nxt.slow_en     = wr_byte[dcm_pkg::SEN_BIT];
                    s_nxt.clk_sel_req = wr_byte[dcm_pkg::CSEL_BIT];
                    s_nxt.idle        = wr_byte[dcm_pkg::IDLE_BIT];
                    s_nxt.tg_halt     = wr_byte[dcm_pkg::TGH_BIT] & ~wr_byte[dcm_pkg::IDLE_BIT];
                end
                dcm_pkg::OFS_TB_CTRL: begin
                    s_nxt.tb_en  = wr_byte[dcm_pkg::TBEN_BIT];
                    s_nxt.tb_src = wr_byte[2:0];
                end
                dcm_pkg::OFS_MODE_STAT: begin
                    // a latch set in this same cycle survives the clear
                    if (wr_byte[dcm_pkg::ST_IRQ] && !(s_nxt.irq_latch && !s_r.irq_latch)) begin
                        s_nxt.irq_latch = 1'b0;
                    end
                end
                default: s_nxt.irq_latch = s_nxt.irq_latch;
            endcase
        end

        // read data captured with the ack
        if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
            case (wb_adr_i)
                dcm_pkg::OFS_SYS_ONE:
                    s_nxt.dat = {24'h000000, s_r.stop, s_r.relm, s_r.retm, 5'h00};
                dcm_pkg::OFS_SYS_TWO:
                    s_nxt.dat = {24'h000000, s_r.fast_en, s_r.slow_en, s_r.sel_slow_act,
                                 s_r.idle, 1'b0, s_r.tg_halt, 2'h0};
                dcm_pkg::OFS_TB_CTRL:
                    s_nxt.dat = {28'h0000000, s_r.tb_en, s_r.tb_src};
                dcm_pkg::OFS_MODE_STAT:
                    s_nxt.dat = {25'h0000000, s_r.irq_latch, slow_osc_on, fast_osc_on,
                                 s_r.mode};
                default:
                    s_nxt.dat = 32'h00000000;
            endcase
        end

        if (bad_enables) begin
            s_nxt         = dcm_pkg::DCM_RESET_ST;
            s_nxt.rst_req = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= dcm_pkg::DCM_RESET_ST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o            = s_r.ack;
    assign wb_dat_o            = s_r.dat;
    assign fast_osc_on         = s_r.fast_en & (s_r.mode != dcm_pkg::stop_hold);
    assign slow_osc_on         = s_r.slow_en & (s_r.mode != dcm_pkg::stop_hold);
    assign slow_pins_dedicated = s_r.slow_en;
    assign cpu_clk_en          = is_run(s_r.mode);
    assign wdt_clk_en          = is_run(s_r.mode);
    assign periph_clk_en       = !is_stopped(s_r.mode) && (s_r.mode != dcm_pkg::fast_base_sleep)
                                 && (s_r.mode != dcm_pkg::slow_base_sleep);
    assign tbt_clk_en          = !is_stopped(s_r.mode);
    assign div_low_run         = !divider_stopped(s_r.mode);
    assign main_clk_slow       = s_r.sel_slow_act;
    assign machine_cycle       = s_r.mc_pulse;
    assign time_base_irq_latch = s_r.irq_latch;
    assign time_base_irq_take  = s_r.irq_latch & interrupt_master_enable &
                                 time_base_irq_enable & s_r.tb_en;
    assign sys_reset_req       = s_r.rst_req;
    assign stop_resume         = s_r.resume;

    chk_pins_dedicated: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::dual_fast_run) |-> slow_pins_dedicated)
        else $error("slow pins released in dual fast run");
    chk_reset_mode: assert property (@(posedge clk)
        $past(reset) |-> (s_r.mode == dcm_pkg::single_fast_run) && !slow_osc_on)
        else $error("reset did not give single fast run");
    chk_switch_boundary: assert property (@(posedge clk) disable iff (reset)
        $changed(s_r.sel_slow_act) && !$past(is_stopped(s_r.mode)) &&
        !$past(bad_enables) |-> s_r.mc_pulse)
        else $error("clock source switched inside a machine cycle");
    chk_slow_only_entry: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::slow_run_fast_on) && !s_r.fast_en && s_r.sel_slow_act &&
        !s_r.stop && !s_r.tg_halt && !s_r.idle && !bad_enables
        |=> (s_r.mode == dcm_pkg::slow_only_run))
        else $error("fast enable clear did not reach slow only run");
    chk_divider_slow: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::slow_only_run) |-> !div_low_run && cpu_clk_en)
        else $error("divider low stages running in slow only run");
    chk_idle_release: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::dual_fast_idle) && wake_irq && !bad_enables
        |=> (s_r.mode == dcm_pkg::dual_fast_run) && !s_r.idle && cpu_clk_en)
        else $error("dual idle release wrong");
    chk_base_sleep_exit: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::slow_base_sleep) && tb_fall && !bad_enables
        |=> (s_r.mode == dcm_pkg::slow_only_run) && !s_r.tg_halt
            && (s_r.irq_latch == $past(s_r.tb_at_entry) || $past(s_r.irq_latch)))
        else $error("base sleep exit wrong");
    chk_stop_osc_off: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::stop_hold) |-> !fast_osc_on && !slow_osc_on && !periph_clk_en)
        else $error("oscillator running in stop");
    chk_bad_enable_reset: assert property (@(posedge clk) disable iff (reset)
        bad_enables |=> sys_reset_req && (s_r.mode == dcm_pkg::single_fast_run))
        else $error("illegal enable write gave no reset");
    chk_irq_take: assert property (@(posedge clk) disable iff (reset)
        time_base_irq_take |-> s_r.tb_en && interrupt_master_enable &&
            time_base_irq_enable && s_r.irq_latch)
        else $error("time base irq serviced without all enables");
    chk_slow_only_idle: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::slow_only_idle) |->
            !fast_osc_on && slow_osc_on && !cpu_clk_en && periph_clk_en && !div_low_run)
        else $error("slow only idle gating wrong");
    chk_slow_idle_fast: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::slow_idle_fast_on) |->
            fast_osc_on && slow_osc_on && !cpu_clk_en && periph_clk_en && !div_low_run)
        else $error("slow idle with fast oscillator gating wrong");
    chk_base_sleep_gates: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::slow_base_sleep) |->
            !cpu_clk_en && !periph_clk_en && tbt_clk_en && !div_low_run)
        else $error("base sleep clock gating wrong");
    chk_fast_sleep_exit: assert property (@(posedge clk) disable iff (reset)
        (s_r.mode == dcm_pkg::fast_base_sleep) && tb_fall && !wr_go
        |=> cpu_clk_en && div_low_run && !s_r.tg_halt)
        else $error("fast base sleep exit wrong");
    chk_stop_resume: assert property (@(posedge clk) disable iff (reset)
        stop_resume |-> cpu_clk_en && !s_r.stop && !is_stopped(s_r.mode))
        else $error("stop resume pulse outside a run mode");
    chk_wb_ack_pulse: assert property (@(posedge clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

// ### testbench/dual_clock_mode_controller_bench.sv
// randomised self-checking bench for the dual clock mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    check_count++; \
    if ((a) !== (b)) begin \
        fail_count++; \
        $display("Error at %0t: got %h want %h", $time, a, b); \
    end \
end
module dual_clock_mode_controller_bench;
    logic        clk, reset, cyc, stb, we, ack, fast_tick, slow_tick, wake_irq, rel_pin;
    logic        ime, tie, f_on, s_on, pins, cpu_en, wdt_en, per_en, tbt_en, div_en;
    logic        slow_sel, mc, latch, take, rst_req, resume;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, dout, rdat;
    logic [7:0]  tb_src, n;
    int          fail_count, check_count, cycles, seed;

    // short warm-up keeps the stop scenario within a few dozen cycles
    dcm_dual_clock_mode_controller #(.WARMUP_CYCLES(16'h0004)) i_dcm_dual_clock_mode_controller (
        .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(dout),
        .fast_tick(fast_tick), .slow_tick(slow_tick), .wake_irq(wake_irq),
        .stop_release_pin(rel_pin), .tb_sources(tb_src), .interrupt_master_enable(ime),
        .time_base_irq_enable(tie), .fast_osc_on(f_on), .slow_osc_on(s_on),
        .slow_pins_dedicated(pins), .cpu_clk_en(cpu_en), .wdt_clk_en(wdt_en),
        .periph_clk_en(per_en), .tbt_clk_en(tbt_en), .div_low_run(div_en),
        .main_clk_slow(slow_sel), .machine_cycle(mc), .time_base_irq_latch(latch),
        .time_base_irq_take(take), .sys_reset_req(rst_req), .stop_resume(resume));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // oscillator ticks at fixed spacing; cpu flags random every cycle
    always @(posedge clk) begin
        cycles++;
        fast_tick <= (cycles % 2 == 0);
        slow_tick <= (cycles % 8 == 0);
        ime <= 1'($random(seed));
        tie <= 1'($random(seed));
        if (cycles >= 20000) begin
            fail_count++;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one classic cycle; upper data bits and sel bits above bit 0 are random noise
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1 | 4'($random(seed));
        wdat <= {24'($random(seed)), d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic want_mode(input logic [3:0] m);
        int k;
        k = 0;
        do begin
            bus(1'b0, dcm_pkg::OFS_MODE_STAT, 8'h00);
            k++;
        end while (rdat[3:0] !== m && k < 40);
        `CHK(rdat[3:0], m)
    endtask

    // ticks of the active oscillator between two machine cycle pulses
    task automatic mc_count(input logic slow);
        int k, t;
        k = 0;
        t = 0;
        while (mc !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        do begin
            @(posedge clk);
            t += int'(slow ? slow_tick : fast_tick);
            k++;
        end while (mc !== 1'b1 && k < 200);
        `CHK(t, 4)
    endtask

    task automatic pulses(input int len);
        n = 8'h00;
        repeat (len) begin
            @(posedge clk);
            n = n + {7'h00, rst_req | resume};
        end
    endtask

    initial begin
        seed = 32'hdb2efad2;
        {cyc, stb, we, wake_irq, rel_pin, ime, tie, fast_tick, slow_tick} = '0;
        {adr, sel, wdat, tb_src} = '0;
        reset = 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        `CHK({cpu_en, div_en, s_on, f_on}, 4'hd)
        bus(1'b0, dcm_pkg::OFS_SYS_TWO, 8'h00);
        `CHK(rdat, 32'h80)
        bus(1'b1, 4'h2, 8'hff);
        bus(1'b0, 4'h2, 8'h00);
        `CHK(rdat, 32'h0)
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'hc0);
        want_mode(dcm_pkg::dual_fast_run);
        `CHK({pins, s_on, cpu_en, wdt_en}, 4'hf)
        mc_count(1'b0);
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'hd0);
        want_mode(dcm_pkg::dual_fast_idle);
        `CHK({cpu_en, wdt_en, per_en, f_on, s_on}, 5'h07)
        wake_irq <= 1'b1;
        want_mode(dcm_pkg::dual_fast_run);
        wake_irq <= 1'b0;
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'he0);
        want_mode(dcm_pkg::slow_run_fast_on);
        bus(1'b0, dcm_pkg::OFS_SYS_TWO, 8'h00);
        `CHK({slow_sel, rdat[5], rdat[4]}, 3'h6)
        mc_count(1'b1);
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'h60);
        want_mode(dcm_pkg::slow_only_run);
        `CHK({f_on, div_en, cpu_en}, 3'h1)
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'he0);
        want_mode(dcm_pkg::slow_run_fast_on);
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'hf0);
        want_mode(dcm_pkg::slow_idle_fast_on);
        `CHK({f_on, s_on, cpu_en, per_en, div_en}, 5'h1a)
        wake_irq <= 1'b1;
        want_mode(dcm_pkg::slow_run_fast_on);
        wake_irq <= 1'b0;
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'h60);
        want_mode(dcm_pkg::slow_only_run);
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'h70);
        want_mode(dcm_pkg::slow_only_idle);
        `CHK({f_on, s_on, cpu_en, per_en, div_en}, 5'h0a)
        wake_irq <= 1'b1;
        want_mode(dcm_pkg::slow_only_run);
        wake_irq <= 1'b0;
        tb_src <= 8'h01;
        bus(1'b1, dcm_pkg::OFS_TB_CTRL, 8'h08);
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'h64);
        want_mode(dcm_pkg::slow_base_sleep);
        `CHK({cpu_en, per_en, tbt_en, div_en}, 4'h2)
        tb_src <= 8'h00;
        want_mode(dcm_pkg::slow_only_run);
        `CHK(latch, 1'b1)
        bus(1'b0, dcm_pkg::OFS_SYS_TWO, 8'h00);
        `CHK(rdat[2], 1'b0)
        repeat (6) @(negedge clk) `CHK(take, ime & tie)
        bus(1'b1, dcm_pkg::OFS_MODE_STAT, 8'h40);
        // the clear lands at the ack edge, so look one edge later
        @(posedge clk);
        `CHK(latch, 1'b0)
        tb_src <= 8'h01;
        bus(1'b1, dcm_pkg::OFS_TB_CTRL, 8'h00);
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'h64);
        want_mode(dcm_pkg::slow_base_sleep);
        tb_src <= 8'h00;
        want_mode(dcm_pkg::slow_only_run);
        `CHK(latch, 1'b0)
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'h20);
        pulses(5);
        `CHK(n, 8'h01)
        want_mode(dcm_pkg::single_fast_run);
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'h90);
        want_mode(dcm_pkg::single_idle);
        wake_irq <= 1'b1;
        want_mode(dcm_pkg::single_fast_run);
        wake_irq <= 1'b0;
        tb_src <= 8'h01;
        bus(1'b1, dcm_pkg::OFS_SYS_TWO, 8'h84);
        want_mode(dcm_pkg::fast_base_sleep);
        tb_src <= 8'h00;
        want_mode(dcm_pkg::single_fast_run);
        bus(1'b0, dcm_pkg::OFS_SYS_TWO, 8'h00);
        `CHK(rdat[7:0], 8'h80)
        bus(1'b1, dcm_pkg::OFS_SYS_ONE, 8'hc0);
        want_mode(dcm_pkg::stop_hold);
        `CHK({f_on, s_on, cpu_en, per_en}, 4'h0)
        rel_pin <= 1'b1;
        pulses(30);
        `CHK(n, 8'h01)
        rel_pin <= 1'b0;
        want_mode(dcm_pkg::single_fast_run);
        bus(1'b0, dcm_pkg::OFS_SYS_ONE, 8'h00);
        `CHK(rdat[7], 1'b0)
        report_and_stop;
    end
endmodule
`default_nettype wire
